// ===== design/hcbc_dram_if.sv
// Request and beat handshake between the bus controller and the DRAM sequencer
`default_nettype none
interface hcbc_dram_if;
	logic req;
	logic [31:3] addr;
	logic [7:0] lanes;
	logic [2:0] nbeats;
	logic beat;
	logic busy;
	modport ctl (output req, output addr, output lanes, output nbeats, input beat, input busy);
	modport seq (input req, input addr, input lanes, input nbeats, output beat, output busy);
endinterface : hcbc_dram_if
`default_nettype wire

// ===== design/hcbc_dram_seq.sv
// DRAM row, column and burst address sequencer
`default_nettype none
module hcbc_dram_seq
	import hcbc_pkg::*;
#(
	parameter int RAS_TO_CAS = HCBC_RAS_TO_CAS_CYC,
	parameter int CAS_PULSE = HCBC_CAS_PULSE_CYC
)
(
	input wire logic clk_sys,
	input wire logic resetn,
	hcbc_dram_if.seq dif,
	output logic [4:0] dram_row_strobe_n,
	output logic [7:0] dram_col_strobe_n,
	output logic [11:2] dram_mux_addr,
	output logic [1:0] dram_burst_addr_copy_a,
	output logic [1:0] dram_burst_addr_copy_b
);
	hcbc_dram_st_t state_r;
	logic [3:0] cnt_r;
	logic [2:0] beat_idx_r;
	logic [2:0] nbeats_r;
	logic [31:3] addr_r;
	logic [7:0] lanes_r;
	logic [2:0] row_raw;
	logic [2:0] row_sel;
	logic [1:0] col_step;

	assign row_raw = addr_r[HCBC_ROW_SEL_LSB +: 3];
	assign row_sel = (row_raw >= 3'(HCBC_ROW_COUNT)) ? 3'(HCBC_ROW_COUNT - 1) : row_raw;
	// Burst order steps the low column bits in interleaved order
	assign col_step = addr_r[4:3] ^ beat_idx_r[1:0];
	assign dif.busy = (state_r != HCBC_D_IDLE);

	// Sequencing
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			state_r <= HCBC_D_IDLE;
			cnt_r <= 4'h0;
			beat_idx_r <= 3'h0;
			nbeats_r <= 3'h0;
			addr_r <= '0;
			lanes_r <= 8'h00;
			dif.beat <= 1'b0;
		end
		else
		begin
			dif.beat <= 1'b0;
			case (state_r)
				HCBC_D_IDLE:
					if (dif.req)
					begin
						addr_r <= dif.addr;
						lanes_r <= dif.lanes;
						nbeats_r <= dif.nbeats;
						beat_idx_r <= 3'h0;
						cnt_r <= 4'(RAS_TO_CAS);
						state_r <= HCBC_D_ROW;
					end
				HCBC_D_ROW:
					if (cnt_r == 4'h1)
					begin
						cnt_r <= 4'(CAS_PULSE);
						state_r <= HCBC_D_CAS;
					end
					else
						cnt_r <= cnt_r - 4'h1;
				HCBC_D_CAS:
					if (cnt_r == 4'h1)
					begin
						dif.beat <= 1'b1;
						if (beat_idx_r == nbeats_r - 3'h1)
							state_r <= HCBC_D_IDLE;
						else
						begin
							beat_idx_r <= beat_idx_r + 3'h1;
							cnt_r <= 4'(CAS_PULSE);
						end
					end
					else
						cnt_r <= cnt_r - 4'h1;
				default:
					state_r <= HCBC_D_IDLE;
			endcase
		end
	end

	// DRAM pins
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			dram_row_strobe_n <= 5'h1f;
			dram_col_strobe_n <= 8'hff;
			dram_mux_addr <= '0;
			dram_burst_addr_copy_a <= 2'h0;
			dram_burst_addr_copy_b <= 2'h0;
		end
		else
		begin
			dram_row_strobe_n <= 5'h1f;
			if (state_r != HCBC_D_IDLE)
				dram_row_strobe_n[row_sel] <= 1'b0;
			if (state_r == HCBC_D_CAS)
			begin
				dram_mux_addr <= {addr_r[HCBC_COL_ADDR_LSB +: HCBC_MA_WIDTH - 2], col_step};
				dram_col_strobe_n <= (cnt_r != 4'h1) ? ~lanes_r : 8'hff;
			end
			else
			begin
				dram_mux_addr <= addr_r[HCBC_ROW_ADDR_LSB +: HCBC_MA_WIDTH];
				dram_col_strobe_n <= 8'hff;
			end
			dram_burst_addr_copy_a <= col_step;
			dram_burst_addr_copy_b <= col_step;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	chk_single_row_strobe:
	assert property ($countones(~dram_row_strobe_n) <= 1) else $error("More than one row strobe active");
	chk_copies_identical:
	assert property (dram_burst_addr_copy_a == dram_burst_addr_copy_b) else $error("Burst address copies differ");
endmodule : hcbc_dram_seq
`default_nettype wire

// ===== design/hcbc_pkg.sv
// Shared constants and state types for the host bus controller
`default_nettype none
package hcbc_pkg;
	localparam int HCBC_STRAP_MSB = 31;
	localparam int HCBC_STRAP_LSB = 28;
	localparam int HCBC_STRAP_L2_EN = 3;
	localparam int HCBC_STRAP_ASYNC = 2;
	localparam logic [3:0] HCBC_STRAP_RESET = 4'h0;
	localparam logic [2:0] HCBC_LINE_BEATS = 3'h4;
	localparam logic [2:0] HCBC_SINGLE_BEAT = 3'h1;
	localparam logic [7:0] HCBC_ALL_LANES = 8'hff;
	localparam logic [31:0] HCBC_SMM_BASE = 32'h000a_0000;
	localparam logic [31:0] HCBC_SMM_LAST = 32'h000b_ffff;
	localparam int HCBC_ROW_SEL_LSB = 23;
	localparam int HCBC_ROW_COUNT = 5;
	localparam int HCBC_ROW_ADDR_LSB = 13;
	localparam int HCBC_COL_ADDR_LSB = 5;
	localparam int HCBC_MA_WIDTH = 10;
	localparam int HCBC_CLK_PERIOD_NS = 4;
	localparam int HCBC_RAS_TO_CAS_NS = 8;
	localparam int HCBC_CAS_PULSE_NS = 8;
	localparam int HCBC_RAS_TO_CAS_CYC = (HCBC_RAS_TO_CAS_NS + HCBC_CLK_PERIOD_NS - 1) / HCBC_CLK_PERIOD_NS;
	localparam int HCBC_CAS_PULSE_CYC = (HCBC_CAS_PULSE_NS + HCBC_CLK_PERIOD_NS - 1) / HCBC_CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		HCBC_C_IDLE = 3'h1,
		HCBC_C_T2 = 3'h2,
		HCBC_C_DATA = 3'h4
	} hcbc_cpu_st_t;

	typedef enum logic [6:0] {
		HCBC_S_IDLE = 7'h01,
		HCBC_S_HOLD = 7'h02,
		HCBC_S_STROBE = 7'h04,
		HCBC_S_PARK = 7'h08,
		HCBC_S_CHECK = 7'h10,
		HCBC_S_WB = 7'h20,
		HCBC_S_XFER = 7'h40
	} hcbc_snp_st_t;

	typedef enum logic [2:0] {
		HCBC_D_IDLE = 3'h1,
		HCBC_D_ROW = 3'h2,
		HCBC_D_CAS = 3'h4
	} hcbc_dram_st_t;
endpackage : hcbc_pkg
`default_nettype wire

// ===== design/hcbc_top.sv
// Host bus control: processor cycles, first level snoops and DRAM hand-off
`default_nettype none
module hcbc_top
	import hcbc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [31:3] host_addr_in,
	output logic [31:3] host_addr_out,
	output logic host_addr_oe,
	input wire logic [7:0] byte_lane_en_n,
	input wire logic addr_strobe_n,
	input wire logic mem_io,
	input wire logic data_ctrl,
	input wire logic write_read,
	input wire logic cacheable_n,
	input wire logic host_lock_n,
	input wire logic hit_modified_n,
	input wire logic mgmt_mode_active_n,
	input wire logic smram_locked,
	input wire logic cpu_to_pci,
	input wire logic pci_fwd_ready,
	input wire logic pci_mem_req,
	input wire logic pci_mem_write,
	input wire logic [31:3] pci_mem_addr,
	input wire logic pci_peer,
	input wire logic pci_burst_done,
	output logic bus_ready_n,
	output logic next_addr_n,
	output logic addr_hold,
	output logic inquiry_strobe_n_o,
	output logic inquiry_strobe_oe,
	output logic back_off_n,
	output logic cache_enable_invalidate,
	output logic cpu_fwd_pci,
	output logic [7:0] read_lane_en,
	output logic [3:0] l2_strap,
	output logic pci_phase,
	output logic [4:0] dram_row_strobe_n,
	output logic [7:0] dram_col_strobe_n,
	output logic [11:2] dram_mux_addr,
	output logic [1:0] dram_burst_addr_copy_a,
	output logic [1:0] dram_burst_addr_copy_b
);
	hcbc_cpu_st_t cpu_st_r;
	hcbc_snp_st_t snp_st_r;
	logic strap_done_r;
	logic lock_r;
	logic pci_req_s;
	logic pci_wr_s;
	logic pci_peer_s;
	logic pci_done_s;
	logic [31:3] pci_addr_s;
	logic cyc_wr_r;
	logic cyc_cache_r;
	logic [31:3] cyc_addr_r;
	logic [2:0] beats_r;
	logic [2:0] beat_cnt_r;
	logic snp_wr_r;
	logic [31:3] snp_addr_r;
	logic dram_req_r;
	logic [31:3] dram_addr_r;
	logic [7:0] dram_lanes_r;
	logic [2:0] dram_nbeats_r;
	logic ads_hit;
	logic smm_hit;
	logic tgt_dram;
	logic na_allowed;
	logic beat_src;
	logic back_off_n_now;
	logic dram_free;
	logic snp_go;
	logic dram_go_cpu;
	logic snp_start;
	logic na_now;
	logic first_resp;

	hcbc_dram_if dif ();

	assign dif.req = dram_req_r;
	assign dif.addr = dram_addr_r;
	assign dif.lanes = dram_lanes_r;
	assign dif.nbeats = dram_nbeats_r;

	logic [3:0] l2_strap_q;

	assign l2_strap = l2_strap_q;

	assign ads_hit = (cpu_st_r == HCBC_C_IDLE) && !addr_strobe_n;
	assign smm_hit = (host_addr_in >= HCBC_SMM_BASE[31:3]) && (host_addr_in <= HCBC_SMM_LAST[31:3]);
	assign tgt_dram = mem_io && !cpu_to_pci && !(smram_locked && smm_hit && mgmt_mode_active_n);
	assign na_allowed = strap_done_r && !(l2_strap_q[HCBC_STRAP_L2_EN] && l2_strap_q[HCBC_STRAP_ASYNC]);
	assign beat_src = cpu_fwd_pci ? pci_fwd_ready : dif.beat;
	assign dram_free = !dif.busy && !dram_req_r;
	assign back_off_n_now = (cpu_st_r != HCBC_C_IDLE) && cpu_fwd_pci && pci_req_s && !pci_peer_s && !lock_r;
	assign snp_go = ((snp_st_r == HCBC_S_CHECK) || (snp_st_r == HCBC_S_WB)) && hit_modified_n
		&& dram_free && (cpu_st_r == HCBC_C_IDLE);
	assign dram_go_cpu = (cpu_st_r == HCBC_C_T2) && !cpu_fwd_pci && dram_free && !back_off_n_now;
	assign snp_start = (snp_st_r == HCBC_S_IDLE) && pci_req_s && !pci_peer_s && !lock_r
		&& (cpu_st_r == HCBC_C_IDLE) && addr_strobe_n;
	// A beat cut by back-off is no response, so the cache enable line stays low
	assign first_resp = (cpu_st_r == HCBC_C_DATA) && beat_src && (beat_cnt_r == 3'h0) && !cyc_wr_r && !back_off_n_now;
	assign na_now = na_allowed && ((ads_hit && write_read) || (first_resp && cyc_cache_r));

	// Half-rate PCI phase and sampling of PCI-side requests
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			pci_phase <= 1'b0;
			pci_req_s <= 1'b0;
			pci_wr_s <= 1'b0;
			pci_peer_s <= 1'b0;
			pci_done_s <= 1'b0;
			pci_addr_s <= '0;
		end
		else
		begin
			pci_phase <= !pci_phase;
			if (pci_phase)
			begin
				pci_req_s <= pci_mem_req;
				pci_wr_s <= pci_mem_write;
				pci_peer_s <= pci_peer;
				pci_done_s <= pci_burst_done;
				pci_addr_s <= pci_mem_addr;
			end
		end
	end

	// Cache straps caught once after reset release
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			strap_done_r <= 1'b0;
			l2_strap_q <= HCBC_STRAP_RESET;
		end
		else if (!strap_done_r)
		begin
			l2_strap_q <= host_addr_in[HCBC_STRAP_MSB:HCBC_STRAP_LSB];
			strap_done_r <= 1'b1;
		end
	end

	// Locked sequence tracking
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			lock_r <= 1'b0;
		else if (host_lock_n)
			lock_r <= 1'b0;
		else if (!addr_strobe_n)
			lock_r <= 1'b1;
	end

	// Processor cycle tracking
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			cpu_st_r <= HCBC_C_IDLE;
			cyc_wr_r <= 1'b0;
			cyc_cache_r <= 1'b0;
			cyc_addr_r <= '0;
			cpu_fwd_pci <= 1'b0;
			read_lane_en <= 8'h00;
			beats_r <= 3'h0;
			beat_cnt_r <= 3'h0;
		end
		else
		begin
			case (cpu_st_r)
				HCBC_C_IDLE:
					if (ads_hit)
					begin
						cyc_wr_r <= write_read;
						cyc_cache_r <= !cacheable_n;
						cyc_addr_r <= host_addr_in;
						cpu_fwd_pci <= !tgt_dram;
						read_lane_en <= (!cacheable_n && !write_read) ? HCBC_ALL_LANES : ~byte_lane_en_n;
						beats_r <= !cacheable_n ? HCBC_LINE_BEATS : HCBC_SINGLE_BEAT;
						beat_cnt_r <= 3'h0;
						cpu_st_r <= HCBC_C_T2;
					end
				HCBC_C_T2:
					if (back_off_n_now)
					begin
						cpu_fwd_pci <= 1'b0;
						cpu_st_r <= HCBC_C_IDLE;
					end
					else if (cpu_fwd_pci || dram_go_cpu)
						cpu_st_r <= HCBC_C_DATA;
				HCBC_C_DATA:
					if (back_off_n_now)
					begin
						cpu_fwd_pci <= 1'b0;
						cpu_st_r <= HCBC_C_IDLE;
					end
					else if (beat_src)
					begin
						beat_cnt_r <= beat_cnt_r + 3'h1;
						if (beat_cnt_r == beats_r - 3'h1)
						begin
							cpu_fwd_pci <= 1'b0;
							cpu_st_r <= HCBC_C_IDLE;
						end
					end
				default:
					cpu_st_r <= HCBC_C_IDLE;
			endcase
		end
	end

	// Processor response pins
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			bus_ready_n <= 1'b1;
			next_addr_n <= 1'b1;
			back_off_n <= 1'b1;
			cache_enable_invalidate <= 1'b0;
		end
		else
		begin
			bus_ready_n <= !(beat_src && (cpu_st_r == HCBC_C_DATA) && !back_off_n_now);
			next_addr_n <= !na_now;
			back_off_n <= !back_off_n_now;
			if (snp_st_r == HCBC_S_HOLD)
				cache_enable_invalidate <= snp_wr_r;
			else if (first_resp)
				cache_enable_invalidate <= !cyc_cache_r;
			else
				cache_enable_invalidate <= 1'b0;
		end
	end

	// Snoop sequence and host address ownership
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			snp_st_r <= HCBC_S_IDLE;
			snp_wr_r <= 1'b0;
			snp_addr_r <= '0;
			addr_hold <= 1'b0;
			host_addr_oe <= 1'b0;
			host_addr_out <= '0;
			inquiry_strobe_n_o <= 1'b1;
			inquiry_strobe_oe <= 1'b0;
		end
		else
		begin
			case (snp_st_r)
				HCBC_S_IDLE:
					if (snp_start)
					begin
						snp_wr_r <= pci_wr_s;
						snp_addr_r <= pci_addr_s;
						addr_hold <= 1'b1;
						snp_st_r <= HCBC_S_HOLD;
					end
				HCBC_S_HOLD:
				begin
					host_addr_oe <= 1'b1;
					host_addr_out <= snp_addr_r;
					inquiry_strobe_oe <= 1'b1;
					inquiry_strobe_n_o <= 1'b0;
					snp_st_r <= HCBC_S_STROBE;
				end
				HCBC_S_STROBE:
				begin
					inquiry_strobe_n_o <= 1'b1;
					snp_st_r <= HCBC_S_PARK;
				end
				HCBC_S_PARK:
				begin
					inquiry_strobe_oe <= 1'b0;
					host_addr_oe <= 1'b0;
					snp_st_r <= HCBC_S_CHECK;
				end
				HCBC_S_CHECK:
					if (!hit_modified_n)
						snp_st_r <= HCBC_S_WB;
					else if (snp_go)
						snp_st_r <= HCBC_S_XFER;
				HCBC_S_WB:
					if (snp_go)
						snp_st_r <= HCBC_S_XFER;
				HCBC_S_XFER:
					if (pci_done_s)
					begin
						addr_hold <= 1'b0;
						snp_st_r <= HCBC_S_IDLE;
					end
				default:
					snp_st_r <= HCBC_S_IDLE;
			endcase
		end
	end

	// DRAM request issue
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			dram_req_r <= 1'b0;
			dram_addr_r <= '0;
			dram_lanes_r <= 8'h00;
			dram_nbeats_r <= 3'h0;
		end
		else
		begin
			dram_req_r <= snp_go || dram_go_cpu;
			if (snp_go)
			begin
				dram_addr_r <= snp_addr_r;
				dram_lanes_r <= HCBC_ALL_LANES;
				dram_nbeats_r <= HCBC_LINE_BEATS;
			end
			else if (dram_go_cpu)
			begin
				dram_addr_r <= cyc_addr_r;
				dram_lanes_r <= read_lane_en;
				dram_nbeats_r <= beats_r;
			end
		end
	end

	hcbc_dram_seq u_seq (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.dif(dif.seq),
		.dram_row_strobe_n(dram_row_strobe_n),
		.dram_col_strobe_n(dram_col_strobe_n),
		.dram_mux_addr(dram_mux_addr),
		.dram_burst_addr_copy_a(dram_burst_addr_copy_a),
		.dram_burst_addr_copy_b(dram_burst_addr_copy_b)
	);

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence snoop_drive_s;
		host_addr_oe && inquiry_strobe_oe && !inquiry_strobe_n_o;
	endsequence
	sequence snoop_park_s;
		(inquiry_strobe_oe && inquiry_strobe_n_o) ##1 (!inquiry_strobe_oe && !host_addr_oe);
	endsequence

	chk_snoop_strobe_steps:
	assert property ($rose(addr_hold) |=> snoop_drive_s ##1 snoop_park_s) else $error("Snoop strobe steps wrong");
	chk_turnaround_wait:
	assert property ($rose(inquiry_strobe_oe) |-> $past(addr_hold) && !$past(inquiry_strobe_oe))
		else $error("Strobe driven without turnaround");
	chk_release_high:
	assert property ($fell(inquiry_strobe_oe) |-> $past(inquiry_strobe_n_o)) else $error("Strobe floated while low");
	chk_addr_drive_snoop:
	assert property (host_addr_oe |-> addr_hold && (snp_st_r == HCBC_S_STROBE || snp_st_r == HCBC_S_PARK))
		else $error("Host address driven outside snoop");
	chk_na_async_off:
	assert property (strap_done_r && l2_strap_q[HCBC_STRAP_L2_EN] && l2_strap_q[HCBC_STRAP_ASYNC] |=> next_addr_n)
		else $error("Next address with asynchronous cache");
	chk_na_write_t2:
	assert property (ads_hit && write_read && na_allowed |=> !next_addr_n ##1 next_addr_n)
		else $error("Next address missing in T2");
	chk_bus_ready_n_cause:
	assert property (!bus_ready_n |-> $past(beat_src) && $past(cpu_st_r) == HCBC_C_DATA)
		else $error("Bus ready without data beat");
	chk_lock_no_hold:
	assert property (lock_r |=> !$rose(addr_hold)) else $error("Snoop started during locked sequence");
	chk_hold_release:
	assert property ($fell(addr_hold) |-> $past(pci_done_s) && $past(snp_st_r) == HCBC_S_XFER)
		else $error("Address hold dropped early");
	chk_inv_direction:
	assert property (inquiry_strobe_oe && !inquiry_strobe_n_o |-> cache_enable_invalidate == snp_wr_r)
		else $error("Invalidate level wrong during strobe");
	chk_ken_idle_low:
	assert property (bus_ready_n && next_addr_n && inquiry_strobe_n_o |-> !cache_enable_invalidate)
		else $error("Cache enable line not idle low");
	chk_full_lanes:
	assert property (cpu_st_r != HCBC_C_IDLE && cyc_cache_r && !cyc_wr_r |-> read_lane_en == HCBC_ALL_LANES)
		else $error("Cacheable read without all lanes");
	chk_back_off_n_cause:
	assert property (!back_off_n |-> $past(cpu_fwd_pci) && $past(cpu_st_r) != HCBC_C_IDLE)
		else $error("Back-off without a cycle to abort");
	chk_phase_toggle:
	assert property ($past(resetn) |-> pci_phase != $past(pci_phase)) else $error("PCI phase stalled");
	chk_strap_frozen:
	assert property (strap_done_r |=> $stable(l2_strap_q)) else $error("Strap changed after capture");
endmodule : hcbc_top
`default_nettype wire

// ===== tb/hcbc_cpu_model.sv
// Processor bus model: cycle starts, qualifiers, forwarded beats, hit-modified replies
`default_nettype none
module hcbc_cpu_model
(
	input wire logic clk_sys,
	input wire logic [3:0] strap,
	input wire logic hit_modified_n_en,
	input wire logic bus_ready_n,
	input wire logic next_addr_n,
	input wire logic back_off_n,
	input wire logic inquiry_strobe_n_o,
	input wire logic inquiry_strobe_oe,
	output logic [31:3] cpu_addr,
	output logic addr_strobe_n,
	output logic write_read,
	output logic cacheable_n,
	output logic [7:0] byte_lane_en_n,
	output logic cpu_to_pci,
	output logic pci_fwd_ready,
	output logic hit_modified_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic busy = 1'b0;
	logic [31:3] cyc_addr = '0;
	logic [24:0] idle_pat = 25'h0;
	logic [2:0] hm_cnt = 3'h0;
	// Released address lines change every cycle; straps stay on top
	assign cpu_addr = busy ? cyc_addr : {strap, idle_pat};
	assign hit_modified_n = (hm_cnt == 3'h0);
	initial
	begin
		addr_strobe_n = 1'b1;
		write_read = 1'b0;
		cacheable_n = 1'b1;
		byte_lane_en_n = 8'hff;
		cpu_to_pci = 1'b0;
		pci_fwd_ready = 1'b0;
	end
	always @(negedge clk_sys)
	begin
		idle_pat <= ~idle_pat;
		if (inquiry_strobe_oe === 1'b1 && inquiry_strobe_n_o === 1'b0 && hit_modified_n_en)
			hm_cnt <= 3'h4;
		else if (hm_cnt != 3'h0)
			hm_cnt <= hm_cnt - 3'h1;
	end
	task automatic run_cycle(input logic wr, input logic cch, input logic fwd, input logic [31:3] a,
		input logic [7:0] ben, input int nb, output int rdy, output int na, output logic bo);
		rdy = 0;
		na = 0;
		bo = 1'b0;
		@(negedge clk_sys);
		busy = 1'b1;
		cyc_addr = a;
		write_read = wr;
		cacheable_n = !cch;
		byte_lane_en_n = ben;
		cpu_to_pci = fwd;
		addr_strobe_n = 1'b0;
		for (int i = 0; i < 80 && rdy < nb && !bo; i++)
		begin
			@(negedge clk_sys);
			addr_strobe_n = 1'b1;
			pci_fwd_ready = fwd && i == 20;
			if (next_addr_n === 1'b0)
				na++;
			if (bus_ready_n === 1'b0)
				rdy++;
			if (back_off_n === 1'b0)
				bo = 1'b1;
		end
		pci_fwd_ready = 1'b0;
		busy = 1'b0;
	endtask : run_cycle
endmodule : hcbc_cpu_model
`default_nettype wire

// ===== tb/tb_host_cpu_bus_controller.sv
// Self-checking bench for the host bus controller
`default_nettype none
module tb_host_cpu_bus_controller;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic first; logic cei; logic lanes;} hcbc_tb_beat_t;
	typedef struct packed {logic [31:3] addr; logic inv;} hcbc_tb_snoop_t;
	logic clk_sys = 1'b0, resetn = 1'b0, rst_q = 1'b0, ph_ok = 1'b0, ph_prev, oe_prev, stb_prev, bo;
	logic [31:3] host_addr_in, host_addr_out, cpu_addr, pci_mem_addr = '0;
	logic [7:0] byte_lane_en_n, read_lane_en;
	logic [4:0] dram_row_strobe_n;
	logic [1:0] dram_burst_addr_copy_a, dram_burst_addr_copy_b;
	logic [3:0] l2_strap, strap = 4'h0;
	logic host_addr_oe, addr_strobe_n, write_read, cacheable_n, hit_modified_n, cpu_to_pci, pci_fwd_ready;
	logic bus_ready_n, next_addr_n, addr_hold, inquiry_strobe_n_o, inquiry_strobe_oe, back_off_n;
	logic cache_enable_invalidate, pci_phase, hit_modified_n_en = 1'b0, host_lock_n = 1'b1;
	logic pci_mem_req = 1'b0, pci_mem_write = 1'b0, pci_peer = 1'b0, pci_burst_done = 1'b0;
	hcbc_tb_beat_t beat_q[$];
	hcbc_tb_snoop_t snp_q[$];
	int n_fail = 0, checks_done = 0, cyc = 0, rdy, na;
	always #2 clk_sys = ~clk_sys;
	assign host_addr_in = host_addr_oe ? host_addr_out : cpu_addr;
	hcbc_top u_hcbc_top (.clk_sys, .resetn, .host_addr_in, .host_addr_out, .host_addr_oe, .byte_lane_en_n,
		.addr_strobe_n, .mem_io(1'b1), .data_ctrl(1'b1), .write_read, .cacheable_n, .host_lock_n, .hit_modified_n,
		.mgmt_mode_active_n(1'b1), .smram_locked(1'b0), .cpu_to_pci, .pci_fwd_ready, .pci_mem_req, .pci_mem_write,
		.pci_mem_addr, .pci_peer, .pci_burst_done, .bus_ready_n, .next_addr_n, .addr_hold, .inquiry_strobe_n_o,
		.inquiry_strobe_oe, .back_off_n, .cache_enable_invalidate, .cpu_fwd_pci(), .read_lane_en, .l2_strap,
		.pci_phase, .dram_row_strobe_n, .dram_col_strobe_n(), .dram_mux_addr(), .dram_burst_addr_copy_a,
		.dram_burst_addr_copy_b);
	hcbc_cpu_model u_hcbc_cpu_model (.clk_sys, .strap, .hit_modified_n_en, .bus_ready_n, .next_addr_n, .back_off_n,
		.inquiry_strobe_n_o, .inquiry_strobe_oe, .cpu_addr, .addr_strobe_n, .write_read, .cacheable_n,
		.byte_lane_en_n, .cpu_to_pci, .pci_fwd_ready, .hit_modified_n);
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic report_and_stop;
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	// Row field 5 lies above the last row and must land on row 4
	function automatic logic [31:3] rand_addr();
		return {6'h00, 3'h5, 20'($urandom)};
	endfunction : rand_addr
	task automatic do_reset(input logic [3:0] s);
		@(negedge clk_sys);
		resetn = 1'b0;
		strap = s;
		repeat (12) @(negedge clk_sys);
		check("idle outputs", {bus_ready_n, next_addr_n, back_off_n, inquiry_strobe_oe, addr_hold}, 5'h1c);
		resetn = 1'b1;
		repeat (2) @(negedge clk_sys);
		check("strap", l2_strap, s);
	endtask : do_reset
	task automatic cpu(input logic wr, input logic cch, input logic fwd, input int nb);
		logic [7:0] ben;
		ben = 8'($urandom) & 8'hfe;
		for (int i = 0; i < nb; i++)
			beat_q.push_back(hcbc_tb_beat_t'{i == 0, !wr && !cch, !wr && cch});
		u_hcbc_cpu_model.run_cycle(wr, cch, fwd, rand_addr(), ben, nb, rdy, na, bo);
	endtask : cpu
	task automatic pci_req(input logic w, input logic peer);
		@(negedge clk_sys);
		pci_mem_addr = rand_addr();
		pci_mem_write = w;
		pci_peer = peer;
		pci_mem_req = 1'b1;
		if (!peer)
			snp_q.push_back(hcbc_tb_snoop_t'{pci_mem_addr, w});
	endtask : pci_req
	task automatic wait_hold(input logic v);
		for (int i = 0; i < 30 && addr_hold !== v; i++)
			@(negedge clk_sys);
		check("address hold", addr_hold, v);
	endtask : wait_hold
	task automatic pci_finish;
		wait_hold(1'b1);
		repeat (15) @(negedge clk_sys);
		check("hold in burst", addr_hold, 1'b1);
		pci_burst_done = 1'b1;
		pci_mem_req = 1'b0;
		repeat (2) @(negedge clk_sys);
		pci_burst_done = 1'b0;
		wait_hold(1'b0);
	endtask : pci_finish
	always @(posedge clk_sys)
	begin
		rst_q <= resetn;
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			n_fail++;
			report_and_stop();
		end
	end
	// Watcher: every ready beat and inquiry strobe takes the oldest note
	always @(negedge clk_sys)
	begin
		hcbc_tb_beat_t b;
		hcbc_tb_snoop_t s;
		ph_ok <= rst_q;
		ph_prev <= pci_phase;
		oe_prev <= inquiry_strobe_oe;
		stb_prev <= inquiry_strobe_n_o;
		if (rst_q)
		begin
			if (ph_ok)
				check("pci phase", pci_phase, !ph_prev);
			check("addr copies", dram_burst_addr_copy_a, dram_burst_addr_copy_b);
			if (dram_row_strobe_n !== 5'h1f)
				check("row select", dram_row_strobe_n, 5'h0f);
			if (oe_prev && !inquiry_strobe_oe)
				check("strobe before release", stb_prev, 1'b1);
			if (bus_ready_n === 1'b0 && beat_q.size() == 0)
				check("unexpected ready", 1'b1, 1'b0);
			else if (bus_ready_n === 1'b0)
			begin
				b = beat_q.pop_front();
				if (b.first)
					check("cache enable", cache_enable_invalidate, b.cei);
				if (b.lanes)
					check("read lanes", read_lane_en, 8'hff);
			end
			if (inquiry_strobe_oe === 1'b1 && inquiry_strobe_n_o === 1'b0 && snp_q.size() == 0)
				check("unexpected inquiry", 1'b1, 1'b0);
			else if (inquiry_strobe_oe === 1'b1 && inquiry_strobe_n_o === 1'b0)
			begin
				s = snp_q.pop_front();
				check("inquiry address", host_addr_out, s.addr);
				check("invalidate", cache_enable_invalidate, s.inv);
			end
		end
	end
	initial
	begin
		rdy = $urandom(32'hb75532a4);
		do_reset(4'hc);
		cpu(1'b1, 1'b0, 1'b0, 1);
		check("next address async", na, 0);
		do_reset(4'h0);
		for (int k = 0; k < 8; k++)
		begin
			cpu(k[0], k[1], 1'b0, k[1] ? 4 : 1);
			check("ready count", rdy, k[1] ? 4 : 1);
			if (k[0] || k[1])
				check("next address", na, 1);
		end
		cpu(1'b1, 1'b0, 1'b1, 1);
		check("forwarded ready", rdy, 1);
		for (int k = 0; k < 2; k++)
		begin
			hit_modified_n_en = k[0];
			pci_req(k[0], 1'b0);
			pci_finish();
		end
		pci_req(1'b1, 1'b1);
		repeat (20) @(negedge clk_sys);
		check("peer hold", addr_hold, 1'b0);
		pci_mem_req = 1'b0;
		pci_peer = 1'b0;
		host_lock_n = 1'b0;
		cpu(1'b0, 1'b1, 1'b0, 4);
		pci_req(1'b0, 1'b0);
		repeat (20) @(negedge clk_sys);
		check("locked hold", addr_hold, 1'b0);
		host_lock_n = 1'b1;
		pci_finish();
		fork
			u_hcbc_cpu_model.run_cycle(1'b1, 1'b0, 1'b1, rand_addr(), 8'h0f, 1, rdy, na, bo);
			pci_req(1'b1, 1'b0);
		join
		check("back off", bo, 1'b1);
		pci_finish();
		check("beats left", beat_q.size(), 0);
		check("snoops left", snp_q.size(), 0);
		report_and_stop();
	end
endmodule : tb_host_cpu_bus_controller
`default_nettype wire
